// >>> hw/cfg_loader_pkg.sv
// Purpose: shared constants and types for the parallel flash configuration loader
// Assumes: 20 MHz ref_clk, APB register access with 32-bit data
// Notes: image layout is a rate/option byte, 3 length bytes, payload, then a CRC-8 byte
package cfg_loader_pkg;
   // clock and timing
   localparam int CLK_PERIOD_NS = 50;                 // ref_clk period
   localparam int PROG_MIN_NS = 500;                  // least low pulse on program request
   localparam int PROG_MIN_CYC = (PROG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [4:0] CLEAR_CYCLES = 5'h10;       // memory clearing time in ref_clk cycles
   localparam logic [1:0] RATE_RESET = 2'h3;          // slowest config clock until the header says
   // image layout
   localparam int HDR_BYTES = 4;                      // option byte plus 3 length bytes
   localparam int OPT_KEEP_BIT = 4;                   // keep-port flag in the option byte
   localparam logic [7:0] CRC_POLY = 8'h07;           // crc-8 polynomial
   localparam logic [23:0] ADDR_UP_START = 24'h00_0000;   // start when counting up
   localparam logic [23:0] ADDR_DOWN_START = 24'hff_ffff; // start when counting down
   // apb register map (byte addresses)
   localparam logic [7:0] REG_CTRL = 8'h00;           // user controls after loading
   localparam logic [7:0] REG_STATUS = 8'h04;         // loader state
   localparam logic [7:0] REG_ADDR = 8'h08;           // current flash address
   localparam logic [7:0] REG_COUNT = 8'h0c;          // payload bytes received
   localparam logic [3:0] CTRL_RESET = 4'h4;          // strobe high, others low
   // ctrl field positions
   localparam int CTRL_WIDTH_BIT = 0;                 // width select level after loading
   localparam int CTRL_INIT_BIT = 1;                  // drive init pin high after loading
   localparam int CTRL_STROBE_BIT = 2;                // write strobe level after loading
   localparam int CTRL_BUSY_BIT = 3;                  // busy level after loading, when the image sets the keep-port option

   typedef enum logic [2:0] {
      ST_WAIT, ST_CLEAR, ST_LOAD, ST_CHAIN, ST_USER, ST_FAIL
   } ld_state_t;

   // status register image
   typedef struct packed {
      logic [1:0] rate;        // clock rate option in use
      logic rw_low;            // read/write select low throughout loading
      logic keep_port;         // parallel port kept after loading
      logic chain_active;      // downstream device selected
      logic crc_error;         // crc mismatch found
      logic loaded;            // own image complete
      logic loading;           // clearing or loading in progress
   } status_t;
endpackage

// >>> hw/low_pulse_qual.sv
// Purpose: qualifies an active-low input that has stayed low for a least number of cycles
// Assumes: input synchronous to clk
// Notes: output stays high while the input remains low after qualifying
`timescale 1ns/10ps
module low_pulse_qual #(
   parameter int CYCLES = 10
) (
   input wire logic clk,        // system clock
   input wire logic rst_n,      // synchronised reset, active low
   input wire logic level_n,    // monitored active-low level
   output logic qualified       // low for at least CYCLES cycles
);
   logic [7:0] cnt_r; // low-time counter, saturates at CYCLES

   // count while low, restart on any high sample
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 8'h00;
      end else if (level_n) begin
         cnt_r <= 8'h00;
      end else if (cnt_r != CYCLES[7:0]) begin
         cnt_r <= cnt_r + 8'h01;
      end
   end

   // registered so short glitches never qualify
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         qualified <= 1'b0;
      end else begin
         qualified <= !level_n && (cnt_r >= CYCLES[7:0] - 8'h01);
      end
   end
endmodule

// >>> hw/flash_config_loader.sv
// Purpose: byte-wide parallel flash configuration loader with daisy-chain hand-off
// Assumes: 20 MHz ref_clk, all pin inputs synchronous to it, APB slave for registers
// Notes: config clock is a divided copy of ref_clk; its rate comes from the image header
// Behaviour
// (RQ1) write strobe held high while loading
// (RQ2) width select low while loading
// (RQ3) new address on config clock falling edge
// (RQ4) address order chosen by sampled mode pin
// (RQ5) flash data captured on rising edge
// (RQ6) flash returns byte at driven address
// (RQ7) config clock divided, rate from image
// (RQ8) config clock actively driven for chain
// (RQ9) chain select low after own load
// (RQ10) busy actively driven while loading
// (RQ11) keep-port option retains parallel port pins
// (RQ12) init low during clearing, then released
// (RQ13) crc error drives init low
// (RQ14) done low until successful completion
// (RQ15) 500 ns program low restarts configuration
// (RQ16) program request held high to start
// (RQ17) chained devices strapped slave parallel
// (RQ18) read/write select held low
// (RQ19) user drives init high if unused
// (RQ20) chain select high until own load
`timescale 1ns/10ps
module flash_config_loader (
   input wire logic ref_clk,                    // 20 MHz clock
   input wire logic nrst,                       // async reset, active low
   input wire logic psel,                       // apb select
   input wire logic penable,                    // apb enable
   input wire logic pwrite,                     // apb direction
   input wire logic [7:0] paddr,                // apb byte address
   input wire logic [31:0] pwdata,              // apb write data
   output logic [31:0] prdata,                  // apb read data
   output logic pready,                         // apb ready
   output logic pslverr,                        // apb error on unmapped address
   input wire logic program_request_n,          // restart request, active low
   input wire logic address_order_select,       // 0 counts up, 1 counts down
   input wire logic read_write_select_n,        // must stay low while loading
   output logic [23:0] flash_addr,              // flash address bus
   input wire logic [7:0] flash_data_in,        // flash data bus
   output logic flash_write_strobe_out,         // flash write enable, high = idle
   output logic flash_width_select_out,         // flash byte/word select
   output logic config_clock_out,               // configuration clock
   output logic chain_select_out_n,             // downstream select, active low
   output logic busy_out,                       // busy pin level
   output logic keep_port_out,                  // data/busy/clock stay a parallel port
   input wire logic init_in,                    // init pin level
   output logic init_out,                       // init pin drive value
   output logic init_oe,                        // init pin drive enable
   input wire logic done_in,                    // done pin level
   output logic done_out,                       // done pin drive value
   output logic done_oe                         // done pin drive enable
);
   logic rst_s1_r;                     // reset synchroniser stage 1
   logic rst_n;                        // synchronised reset
   cfg_loader_pkg::ld_state_t state_r; // loader state
   logic prog_long;                    // program request low long enough
   logic restart_r;                    // restart pending until request released
   logic [4:0] clear_cnt_r;            // clearing timer
   logic [1:0] rate_r;                 // config clock rate option
   logic [3:0] half_cnt_r;             // cycles into current clock half
   logic [3:0] half_len;               // cycles per clock half
   logic tick;                         // clock half ends this cycle
   logic down_r;                       // sampled address order
   logic [2:0] hdr_idx_r;              // header bytes received
   logic [23:0] remain_r;              // payload bytes still due
   logic [23:0] count_r;               // payload bytes received
   logic [7:0] crc_r;                  // running crc
   logic keep_r;                       // keep-port option from the image
   logic crc_err_r;                    // crc mismatch seen
   logic rw_low_r;                     // read/write select low throughout
   logic [3:0] ctrl_r;                 // user control register
   logic cfg_active;                   // clearing or loading
   logic rise_edge;                    // config clock rises this cycle
   logic fall_edge;                    // config clock falls this cycle
   cfg_loader_pkg::status_t status;    // status image

   // release reset through two flops; only the second one is used
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rst_s1_r <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n <= rst_s1_r;
      end
   end

   // qualify the program request pulse width
   low_pulse_qual #(.CYCLES(cfg_loader_pkg::PROG_MIN_CYC)) u_prog_qual (
      .clk(ref_clk),
      .rst_n(rst_n),
      .level_n(program_request_n),
      .qualified(prog_long)
   );

   // crc-8 byte update, msb first
   function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [7:0] data);
      logic [7:0] c;
      c = crc ^ data;
      for (int i = 0; i < 8; i++) begin
         c = c[7] ? ({c[6:0], 1'b0} ^ cfg_loader_pkg::CRC_POLY) : {c[6:0], 1'b0};
      end
      return c;
   endfunction

   assign cfg_active = (state_r == cfg_loader_pkg::ST_CLEAR) ||
                       (state_r == cfg_loader_pkg::ST_LOAD);
   // rate option n gives 2^n ref_clk cycles per half period
   assign half_len = 4'h1 << rate_r; // RQ7
   assign tick = (half_cnt_r == half_len - 4'h1);
   // the clock runs during loading and while the chain is fed
   assign rise_edge = tick && !config_clock_out &&
                      ((state_r == cfg_loader_pkg::ST_LOAD) ||
                       (state_r == cfg_loader_pkg::ST_CHAIN));
   assign fall_edge = tick && config_clock_out &&
                      ((state_r == cfg_loader_pkg::ST_LOAD) ||
                       (state_r == cfg_loader_pkg::ST_CHAIN));

   // a qualified low pulse arms a restart; it fires once the pin is high again
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         restart_r <= 1'b0;
      end else if (prog_long) begin
         restart_r <= 1'b1; // RQ15
      end else if (program_request_n) begin
         restart_r <= 1'b0;
      end
   end

   // main sequence
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= cfg_loader_pkg::ST_WAIT;
      end else if (restart_r && program_request_n) begin
         state_r <= cfg_loader_pkg::ST_CLEAR; // RQ15
      end else begin
         unique case (state_r)
            cfg_loader_pkg::ST_WAIT: begin
               // loading starts only with the request pin released
               if (program_request_n) begin
                  state_r <= cfg_loader_pkg::ST_CLEAR; // RQ16
               end
            end
            cfg_loader_pkg::ST_CLEAR: begin
               if (clear_cnt_r == cfg_loader_pkg::CLEAR_CYCLES - 5'h01) begin
                  state_r <= cfg_loader_pkg::ST_LOAD;
               end
            end
            cfg_loader_pkg::ST_LOAD: begin
               // the crc byte arrives after the header and payload
               if (rise_edge && hdr_idx_r == 3'(cfg_loader_pkg::HDR_BYTES) &&
                   remain_r == 24'h00_0000) begin
                  if (crc_r == flash_data_in) begin
                     state_r <= cfg_loader_pkg::ST_CHAIN; // RQ9
                  end else begin
                     state_r <= cfg_loader_pkg::ST_FAIL; // RQ13
                  end
               end
            end
            cfg_loader_pkg::ST_CHAIN: begin
               // the wired done line goes high once every device is loaded
               if (done_in) begin
                  state_r <= cfg_loader_pkg::ST_USER;
               end
            end
            cfg_loader_pkg::ST_USER: begin
               // stays here until a program request
            end
            cfg_loader_pkg::ST_FAIL: begin
               // holds the error until a program request
            end
            default: begin
               state_r <= cfg_loader_pkg::ST_WAIT;
            end
         endcase
      end
   end

   // clearing timer
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         clear_cnt_r <= 5'h00;
      end else if (state_r == cfg_loader_pkg::ST_CLEAR) begin
         clear_cnt_r <= clear_cnt_r + 5'h01;
      end else begin
         clear_cnt_r <= 5'h00;
      end
   end

   // sample the address order when clearing ends
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         down_r <= 1'b0;
      end else if (state_r == cfg_loader_pkg::ST_CLEAR &&
                   clear_cnt_r == cfg_loader_pkg::CLEAR_CYCLES - 5'h01) begin
         down_r <= address_order_select; // RQ4
      end
   end

   // config clock divider; the clock parks low outside loading and chaining
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         half_cnt_r <= 4'h0;
         config_clock_out <= 1'b0;
      end else if (state_r == cfg_loader_pkg::ST_LOAD ||
                   state_r == cfg_loader_pkg::ST_CHAIN) begin
         half_cnt_r <= tick ? 4'h0 : half_cnt_r + 4'h1;
         if (tick) begin
            config_clock_out <= !config_clock_out; // RQ8
         end
      end else begin
         half_cnt_r <= 4'h0;
         config_clock_out <= 1'b0;
      end
   end

   // flash address: set at clearing end, stepped only as the clock falls
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         flash_addr <= cfg_loader_pkg::ADDR_UP_START;
      end else if (state_r == cfg_loader_pkg::ST_CLEAR) begin
         flash_addr <= address_order_select ? cfg_loader_pkg::ADDR_DOWN_START : // RQ4
                       cfg_loader_pkg::ADDR_UP_START;
      end else if (fall_edge) begin
         flash_addr <= down_r ? flash_addr - 24'h00_0001 : flash_addr + 24'h00_0001; // RQ3
      end
   end

   // byte capture on the rising clock: header, payload length and crc
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         hdr_idx_r <= 3'h0;
         remain_r <= 24'h00_0000;
         count_r <= 24'h00_0000;
         crc_r <= 8'h00;
         rate_r <= cfg_loader_pkg::RATE_RESET;
         keep_r <= 1'b0;
      end else if (state_r == cfg_loader_pkg::ST_CLEAR) begin
         hdr_idx_r <= 3'h0;
         remain_r <= 24'h00_0000;
         count_r <= 24'h00_0000;
         crc_r <= 8'h00;
         rate_r <= cfg_loader_pkg::RATE_RESET;
         keep_r <= 1'b0;
      end else if (rise_edge && state_r == cfg_loader_pkg::ST_LOAD) begin
         if (hdr_idx_r != 3'(cfg_loader_pkg::HDR_BYTES)) begin
            hdr_idx_r <= hdr_idx_r + 3'h1;
            crc_r <= crc8_step(crc_r, flash_data_in); // RQ5
            if (hdr_idx_r == 3'h0) begin
               // rate takes effect from the next clock half
               rate_r <= flash_data_in[1:0]; // RQ7
               keep_r <= flash_data_in[cfg_loader_pkg::OPT_KEEP_BIT]; // RQ11
            end else begin
               remain_r <= {remain_r[15:0], flash_data_in};
            end
         end else if (remain_r != 24'h00_0000) begin
            remain_r <= remain_r - 24'h00_0001;
            count_r <= count_r + 24'h00_0001;
            crc_r <= crc8_step(crc_r, flash_data_in); // RQ5
         end
      end
   end

   // crc error flag is sticky until a restart clears it
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         crc_err_r <= 1'b0;
      end else if (state_r == cfg_loader_pkg::ST_CLEAR) begin
         crc_err_r <= 1'b0;
      end else if (state_r == cfg_loader_pkg::ST_FAIL) begin
         crc_err_r <= 1'b1;
      end
   end

   // read/write select must stay low; any high sample while loading is recorded
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rw_low_r <= 1'b1;
      end else if (state_r == cfg_loader_pkg::ST_WAIT) begin
         rw_low_r <= 1'b1;
      end else if (cfg_active && read_write_select_n) begin
         rw_low_r <= 1'b0;
      end
   end

   // pin outputs: fixed levels while loading, user controls and the image keep-port option afterwards
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         flash_write_strobe_out <= 1'b1;
         flash_width_select_out <= 1'b0;
         busy_out <= 1'b0;
         keep_port_out <= 1'b0;
      end else if (state_r == cfg_loader_pkg::ST_USER) begin
         flash_write_strobe_out <= ctrl_r[cfg_loader_pkg::CTRL_STROBE_BIT];
         flash_width_select_out <= ctrl_r[cfg_loader_pkg::CTRL_WIDTH_BIT]; // RQ2
         busy_out <= keep_r & ctrl_r[cfg_loader_pkg::CTRL_BUSY_BIT]; // RQ11
         keep_port_out <= keep_r; // RQ11
      end else begin
         flash_write_strobe_out <= 1'b1; // RQ1
         flash_width_select_out <= 1'b0; // RQ2
         busy_out <= 1'b0; // RQ10
         keep_port_out <= 1'b0;
      end
   end

   // chain select: downstream stays deselected until our own image is in
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         chain_select_out_n <= 1'b1; // RQ20
      end else begin
         chain_select_out_n <= (state_r != cfg_loader_pkg::ST_CHAIN); // RQ9
      end
   end

   // init pin: pulled low while clearing and on crc error, optionally driven high later
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         init_out <= 1'b0;
         init_oe <= 1'b1;
      end else if (state_r == cfg_loader_pkg::ST_CLEAR || state_r == cfg_loader_pkg::ST_WAIT) begin
         init_out <= 1'b0; // RQ12
         init_oe <= 1'b1;
      end else if (state_r == cfg_loader_pkg::ST_FAIL) begin
         init_out <= 1'b0; // RQ13
         init_oe <= 1'b1;
      end else if (state_r == cfg_loader_pkg::ST_USER) begin
         init_out <= 1'b1; // RQ19
         init_oe <= ctrl_r[cfg_loader_pkg::CTRL_INIT_BIT];
      end else begin
         init_out <= 1'b0; // RQ12
         init_oe <= 1'b0;
      end
   end

   // done pin: driven low until our own image is in and checked
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         done_out <= 1'b0;
         done_oe <= 1'b1;
      end else begin
         done_out <= 1'b0;
         done_oe <= !(state_r == cfg_loader_pkg::ST_CHAIN ||
                      state_r == cfg_loader_pkg::ST_USER); // RQ14
      end
   end

   // status image for software
   always_comb begin
      status.rate = rate_r;
      status.rw_low = rw_low_r;
      status.keep_port = keep_r;
      status.chain_active = (state_r == cfg_loader_pkg::ST_CHAIN);
      status.crc_error = crc_err_r;
      status.loaded = (state_r == cfg_loader_pkg::ST_CHAIN) ||
                      (state_r == cfg_loader_pkg::ST_USER);
      status.loading = cfg_active;
   end

   // apb: answer prepared in the setup cycle, so every access has no wait states
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (psel && !penable) begin
         pready <= 1'b1;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         unique case (paddr)
            cfg_loader_pkg::REG_CTRL: prdata <= {28'h000_0000, ctrl_r};
            cfg_loader_pkg::REG_STATUS: prdata <= {24'h00_0000, status};
            cfg_loader_pkg::REG_ADDR: prdata <= {8'h00, flash_addr};
            cfg_loader_pkg::REG_COUNT: prdata <= {8'h00, count_r};
            default: pslverr <= 1'b1; // unmapped reads zero with error
         endcase
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // control register write at the completing access edge
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= cfg_loader_pkg::CTRL_RESET;
      end else if (psel && penable && pready && pwrite && paddr == cfg_loader_pkg::REG_CTRL) begin
         ctrl_r <= pwdata[3:0];
      end
   end
endmodule

// >>> dv/cfg_loader_monitor.sv
// Purpose: pin and bus checks for the flash config loader
// Assumes: only top-level ports are visible
// Notes: done driven low marks the configuration phase
`timescale 1ns/10ps
module cfg_loader_monitor (
   input wire logic ref_clk, // clock
   input wire logic nrst, // reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic [7:0] paddr, // apb address
   input wire logic pready, // apb ready
   input wire logic pslverr, // apb error
   input wire logic program_request_n, // restart request
   input wire logic [23:0] flash_addr, // flash address
   input wire logic flash_write_strobe_out, // write strobe
   input wire logic flash_width_select_out, // width select
   input wire logic config_clock_out, // config clock
   input wire logic chain_select_out_n, // chain select
   input wire logic init_out, // init value
   input wire logic init_oe, // init enable
   input wire logic done_oe // done enable
);
   logic [5:0] low_cnt; // cycles init held low
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // saturates so a long clear cannot wrap under the bound
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         low_cnt <= 6'h00;
      end else if (!(init_oe && !init_out)) begin
         low_cnt <= 6'h00;
      end else if (low_cnt != 6'h3f) begin
         low_cnt <= low_cnt + 6'h01;
      end
   end
   // ten low samples then the request returns high
   sequence prog_long;
      !program_request_n [*8] ##1 !program_request_n [*2] ##1 program_request_n;
   endsequence
   strobe_high_a: assert property (done_oe |-> flash_write_strobe_out)
      else $error("write strobe low while configuring");
   width_low_a: assert property (done_oe |-> !flash_width_select_out)
      else $error("width select high while configuring");
   addr_fall_a: assert property ($changed(flash_addr) && $past(config_clock_out)
      |-> !config_clock_out) else $error("address moved off a falling clock");
   chain_hold_a: assert property (!chain_select_out_n |-> !done_oe && !init_oe)
      else $error("chain selected before own load");
   init_clear_a: assert property ($fell(init_oe) && !$past(init_out)
      |-> low_cnt >= 6'h10) else $error("init released before clearing ended");
   done_chain_a: assert property ($fell(done_oe) |-> ##[0:2] !chain_select_out_n)
      else $error("done released without chain hand-off");
   prog_restart_a: assert property (prog_long |-> ##[1:4] (done_oe && init_oe && !init_out))
      else $error("program request did not restart");
   apb_ready_a: assert property (psel && !penable |=> pready)
      else $error("apb answer late");
   apb_err_a: assert property (pready |-> pslverr == (paddr > 8'h0c || |paddr[1:0]))
      else $error("apb error flag wrong");
endmodule
bind flash_config_loader cfg_loader_monitor cfg_loader_monitor_inst (.*);

// >>> dv/flash_model.sv
// Purpose: byte-wide flash holding one loader image
// Assumes: image sits at the bottom, or mirrored at the top when counting down
// Notes: crc byte comes from the bench so it can be corrupted
`timescale 1ns/10ps
module flash_model (
   input wire logic [23:0] flash_addr, // address from loader
   input wire logic down, // image stored from the top
   input wire logic [7:0] crc, // image check byte
   output logic [7:0] flash_data_in // byte at the address
);
   logic [23:0] idx; // offset into the image
   logic [7:0] img [6] = '{8'h10, 8'h00, 8'h00, 8'h02, 8'ha5, 8'h3c}; // rate 0, keep, 2 bytes
   // outside the image the array holds a changing pattern, never a stale byte
   always_comb begin
      idx = down ? 24'hff_ffff - flash_addr : flash_addr;
      flash_data_in = (idx < 24'h00_0006) ? img[idx[2:0]] : idx[7:0] ^ 8'h5a;
      if (idx == 24'h00_0006) begin
         flash_data_in = crc;
      end
   end
endmodule

// >>> dv/flash_config_loader_tb.sv
// Purpose: self-checking bench for the flash config loader
// Assumes: init and done pins pulled up on the board
// Notes: second load counts down and carries a bad crc
`timescale 1ns/10ps
module flash_config_loader_tb;
   logic ref_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, e, pready, pslverr;
   logic [7:0] paddr = 8'h00, flash_data_in, crc_v = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, q;
   logic program_request_n = 1, address_order_select = 0, read_write_select_n = 0;
   logic [23:0] flash_addr;
   logic flash_write_strobe_out, flash_width_select_out, config_clock_out, chain_select_out_n;
   logic busy_out, keep_port_out, init_in, init_out, init_oe, done_in, done_out, done_oe;
   logic [7:0] img [6] = '{8'h10, 8'h00, 8'h00, 8'h02, 8'ha5, 8'h3c}; // same bytes as flash
   int err_count = 0, cmp_count = 0, cyc = 0;
   assign init_in = init_oe ? init_out : 1'b1; // pull-up
   assign done_in = done_oe ? done_out : 1'b1; // pull-up
   flash_config_loader flash_config_loader_inst (.*);
   flash_model flash_model_inst (.flash_addr, .down(address_order_select), .crc(crc_v),
      .flash_data_in);
   initial forever #25 ref_clk = ~ref_clk;
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
      cmp_count++;
      if (s !== x) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", n, x, s);
      end
   endtask
   // one apb transfer; answer taken at the rising edge that sees pready high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic final_report;
      $display("mismatches %0d of %0d compares", err_count, cmp_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // crc-8, poly 07, msb first
   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
      c = c ^ b;
      for (int i = 0; i < 8; i++) begin
         c = c[7] ? (c << 1) ^ 8'h07 : c << 1;
      end
      return c;
   endfunction
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         err_count++;
         final_report();
      end
   end
   initial begin
      foreach (img[i]) crc_v = crc8(crc_v, img[i]);
      repeat (16) @(posedge ref_clk);
      chk("strobe", flash_write_strobe_out, 1'h1);
      chk("width", flash_width_select_out, 1'h0);
      chk("chain", chain_select_out_n, 1'h1);
      chk("done_init", {done_oe, init_oe, init_out}, 3'h6);
      nrst <= 1'b1;
      while (config_clock_out !== 1'b1) @(negedge ref_clk);
      chk("addr_up", flash_addr, 24'h00_0000);
      chk("busy", busy_out, 1'h0);
      chk("init_rel", init_oe, 1'h0);
      while (keep_port_out !== 1'b1) @(negedge ref_clk);
      apb(1'b0, 8'h04, 32'h0000_0000);
      chk("status", q & 32'h0000_00f6, 32'h0000_0032);
      apb(1'b0, 8'h0c, 32'h0000_0000);
      chk("count", q, 32'h0000_0002);
      apb(1'b1, 8'h00, 32'h0000_000b);
      repeat (2) @(negedge ref_clk);
      chk("user_pins", {flash_width_select_out, flash_write_strobe_out, busy_out}, 3'h5);
      chk("init_hi", {init_oe, init_out}, 2'h3);
      apb(1'b0, 8'h40, 32'h0000_0000);
      chk("slverr", {e, q[0]}, 2'h2);
      program_request_n <= 1'b0;
      repeat (5) @(posedge ref_clk);
      program_request_n <= 1'b1;
      repeat (5) @(posedge ref_clk);
      @(negedge ref_clk);
      chk("short_pulse", done_oe, 1'h0);
      address_order_select <= 1'b1;
      crc_v <= ~crc_v;
      program_request_n <= 1'b0;
      repeat (12) @(posedge ref_clk);
      program_request_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk);
      chk("restart", {done_oe, init_oe, init_out, flash_write_strobe_out}, 4'hd);
      while (config_clock_out !== 1'b1) @(negedge ref_clk);
      chk("addr_dn", flash_addr, 24'hff_ffff);
      while (init_oe !== 1'b1) @(negedge ref_clk);
      chk("fail_pins", {init_out, chain_select_out_n, done_oe}, 3'h3);
      apb(1'b0, 8'h04, 32'h0000_0000);
      chk("crc_flag", q & 32'h0000_0006, 32'h0000_0004);
      final_report();
   end
endmodule
